// ### xor_unit_pkg.sv
// Package: shared types and constants for the exclusive-or slice
// Assumes: included before the slice modules; nothing else needed
package xor_unit_pkg;

   localparam int        DATA_W         = 32;
   localparam int        IMM_W          = 13;
   localparam int        WIN_W          = 5;
   localparam int        PIL_W          = 4;
   localparam int        FPQ_DEPTH      = 4;
   localparam int        ICR_W          = 8;
   localparam int        DELAY_SLOTS    = 3;
   // Field positions inside an instruction word
   localparam int        OP_HI          = 31;
   localparam int        OP_LO          = 30;
   localparam int        OP3_HI         = 24;
   localparam int        OP3_LO         = 19;
   localparam int        ISEL_BIT       = 13;
   // Encodings
   localparam logic [1:0] OP_ARITH       = 2'h2;
   localparam logic [5:0] OP3_XOR        = 6'h03;
   localparam logic [5:0] OP3_XNOR       = 6'h07;
   localparam logic [5:0] OP3_XOR_FLAGS  = 6'h13;
   localparam logic [5:0] OP3_XNOR_FLAGS = 6'h17;
   localparam logic [5:0] OP3_WR_MULSTEP = 6'h30;
   // Values after reset
   localparam logic [31:0] RESET_FETCH_ADDR = 32'h0000_0000;
   localparam logic [7:0]  ICR_RESET        = 8'h00;

   // Condition codes
   typedef struct packed {
      logic neg;
      logic zero;
      logic ovf;
      logic carry;
   } icc_t;

   // Decoded instruction fields
   typedef struct packed {
      logic        valid;
      logic [4:0]  dest;
      logic [4:0]  src1;
      logic [4:0]  src2;
      logic        isel;
      logic [12:0] short_immediate;
      logic [1:0]  op;
      logic [5:0]  op3;
   } instr_t;

   // Result handed to the register file
   typedef struct packed {
      logic        wr_en;
      logic [4:0]  addr;
      logic [31:0] data;
   } rf_write_t;

endpackage

// ### xor_operand.sv
// Operand selector: register or sign-extended short immediate
// Assumes: purely combinational, instruction fields already split out
`timescale 1ns/1ps
`default_nettype none
module xor_operand #(
   parameter int DATA_W = 32,
   parameter int IMM_W  = 13
) (
   // Selection
   input  wire logic              ISEL_IN,
   input  wire logic [IMM_W-1:0]  IMM_IN,
   input  wire logic [DATA_W-1:0] REG_IN,
   // Result
   output logic      [DATA_W-1:0] OPERAND_OUT
);
   // Refuse an immediate that cannot be sign-extended into the data width
   if (IMM_W >= DATA_W) begin : g_bad_imm
      $error("immediate wider than data");
   end

   // Immediate sign-extended to the data width
   always_comb begin
      OPERAND_OUT = ISEL_IN ? {{(DATA_W-IMM_W){IMM_IN[IMM_W-1]}}, IMM_IN} : REG_IN;
   end
endmodule
`default_nettype wire

// ### xor_logic_y_write_reset.sv
// Exclusive-or slice with delayed multiply-step register write and reset state
// Assumes: decode supplies one instruction per valid cycle; register file reads same cycle
// Function
// - Second operand: source two when select is 0, else sign-extended 13-bit immediate.
// - Multiply-step register write loads source one xor second operand.
// - That write decodes from op 10 and op3 110000; destination ignored.
// - A trap within three instructions after the write sees the new value.
// - Opcode 000111 writes source one xor inverted operand; flags untouched.
// - Opcode 010111 does that and sets N, Z, clears V and C.
// - Opcode 000011 writes source one xor operand; flags untouched.
// - Opcode 010011 writes xor result and sets N, Z, clears V and C.
// - Power-on, watchdog and software reset all enter the reset trap.
// - Reset sets supervisor mode and clears trap enable.
// - Watchdog and software reset leave FPU enable, level, prior mode, window alone; power-on reset clears them.
// - After reset fetching starts at virtual address zero.
// - Reset initialises cache control and empties the FPU queue, clearing its flag.
// - FPU status writes are accepted only while FPU enable is set.
`timescale 1ns/1ps
`default_nettype none
module xor_logic_y_write_reset #(
   parameter int DATA_W = 32
) (
   // Clock and reset
   input  wire logic                              CLOCK_IN,
   input  wire logic                              RST_N_IN,
   // Reset sources from within the clock domain
   input  wire logic                              WATCHDOG_RST_IN,
   input  wire logic                              SOFT_RST_IN,
   // Instruction and operands
   input  wire xor_unit_pkg::instr_t              INSTR_IN,
   input  wire logic [DATA_W-1:0]                 SRC1_DATA_IN,
   input  wire logic [DATA_W-1:0]                 SRC2_DATA_IN,
   input  wire logic                              TRAP_IN,
   // Processor state writes from other units
   input  wire logic                              STATE_WR_IN,
   input  wire logic                              FPU_ON_FLAG_IN,
   input  wire logic [3:0]                        IRQ_LEVEL_IN,
   input  wire logic                              PRIOR_MODE_FLAG_IN,
   input  wire logic [4:0]                        WINDOW_POINTER_IN,
   input  wire logic                              TRAP_ALLOW_FLAG_IN,
   input  wire logic                              SUPERVISOR_IN,
   input  wire logic                              FPU_STATE_WR_IN,
   input  wire logic [DATA_W-1:0]                 FPU_STATE_DATA_IN,
   input  wire logic                              FPU_QUEUE_PUSH_IN,
   // Results
   output xor_unit_pkg::rf_write_t                RF_WRITE_OUT,
   output xor_unit_pkg::icc_t                     ICC_OUT,
   output logic [DATA_W-1:0]                      MUL_STEP_OUT,
   output logic [DATA_W-1:0]                      MUL_STEP_TRAP_VIEW_OUT,
   // Processor state
   output logic                                   SUPERVISOR_OUT,
   output logic                                   TRAP_ALLOW_FLAG_OUT,
   output logic                                   FPU_ON_FLAG_OUT,
   output logic [3:0]                             IRQ_LEVEL_OUT,
   output logic                                   PRIOR_MODE_FLAG_OUT,
   output logic [4:0]                             WINDOW_POINTER_OUT,
   output logic                                   RESET_TRAP_OUT,
   output logic [31:0]                            FETCH_ADDR_OUT,
   output logic [7:0]                             INSTR_CACHE_CTRL_OUT,
   output logic [DATA_W-1:0]                      FPU_STATE_REG_OUT,
   output logic                                   FPU_QUEUE_NONEMPTY_OUT
);
   // Refuse any data width other than the one the flag logic serves
   if (DATA_W != 32) begin : g_bad_width
      $error("slice serves 32-bit data only");
   end

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_RESET = 2'h1,
      ST_RUN   = 2'h2
   } phase_t;

   typedef struct packed {
      phase_t                  phase;
      logic [DATA_W-1:0]       mul_step;
      logic [DATA_W-1:0]       mul_step_pend;
      logic [1:0]              delay_cnt;
      xor_unit_pkg::rf_write_t rf_wr;
      xor_unit_pkg::icc_t      icc;
      logic                    supervisor;
      logic                    trap_allow;
      logic                    fpu_on;
      logic [3:0]              irq_level;
      logic                    prior_mode;
      logic [4:0]              window;
      logic                    reset_trap;
      logic [31:0]             fetch_addr;
      logic [7:0]              icr;
      logic [DATA_W-1:0]       fpu_state_reg;
      logic [2:0]              fpq_count;
   } state_t;

   state_t s_q;
   state_t s_d;
   logic [DATA_W-1:0] operand;
   logic [DATA_W-1:0] xor_res;
   logic [DATA_W-1:0] xnor_res;

   // -------------------------------------------------------------
   // Datapath
   // -------------------------------------------------------------
   xor_operand #(
      .DATA_W (DATA_W),
      .IMM_W  (xor_unit_pkg::IMM_W)
   ) u_operand (
      .ISEL_IN     (INSTR_IN.isel),
      .IMM_IN      (INSTR_IN.short_immediate),
      .REG_IN      (SRC2_DATA_IN),
      .OPERAND_OUT (operand)
   );

   // Plain and complemented results
   assign xor_res  = SRC1_DATA_IN ^ operand;
   assign xnor_res = SRC1_DATA_IN ^ ~operand;

   // Flag-setting form: N from bit 31, Z on zero, V and C cleared
   function automatic xor_unit_pkg::icc_t flags_of(input logic [31:0] r);
      xor_unit_pkg::icc_t f;
      f.neg   = r[31];
      f.zero  = (r == 32'h0000_0000);
      f.ovf   = 1'b0;
      f.carry = 1'b0;
      return f;
   endfunction

   // -------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------
   always_comb begin
      logic arith;
      logic sync_rst;
      s_d      = s_q;
      arith    = INSTR_IN.valid && (INSTR_IN.op == xor_unit_pkg::OP_ARITH);
      sync_rst = WATCHDOG_RST_IN || SOFT_RST_IN;
      s_d.rf_wr.wr_en = 1'b0;
      s_d.reset_trap  = 1'b0;
      case (s_q.phase)
         ST_RESET: begin
            s_d.phase = ST_RUN;
         end
         ST_RUN: begin
            // Delayed write: commits after three instructions or a trap
            if (s_q.delay_cnt != 2'h0) begin
               if (TRAP_IN) begin
                  s_d.mul_step  = s_q.mul_step_pend;
                  s_d.delay_cnt = 2'h0;
               end else if (INSTR_IN.valid) begin
                  s_d.delay_cnt = s_q.delay_cnt - 2'h1;
                  if (s_q.delay_cnt == 2'h1) s_d.mul_step = s_q.mul_step_pend;
               end
            end
            if (arith) begin
               s_d.rf_wr.addr = INSTR_IN.dest;
               case (INSTR_IN.op3)
                  xor_unit_pkg::OP3_XOR: begin
                     s_d.rf_wr.data = xor_res;
                     s_d.rf_wr.wr_en = 1'b1;
                  end
                  xor_unit_pkg::OP3_XNOR: begin
                     s_d.rf_wr.data = xnor_res;
                     s_d.rf_wr.wr_en = 1'b1;
                  end
                  xor_unit_pkg::OP3_XOR_FLAGS: begin
                     s_d.rf_wr.data = xor_res;
                     s_d.rf_wr.wr_en = 1'b1;
                     s_d.icc = flags_of(xor_res);
                  end
                  xor_unit_pkg::OP3_XNOR_FLAGS: begin
                     s_d.rf_wr.data = xnor_res;
                     s_d.rf_wr.wr_en = 1'b1;
                     s_d.icc = flags_of(xnor_res);
                  end
                  xor_unit_pkg::OP3_WR_MULSTEP: begin
                     // Destination field ignored
                     s_d.mul_step_pend = xor_res;
                     s_d.delay_cnt = 2'(xor_unit_pkg::DELAY_SLOTS);
                  end
                  default: begin
                  end
               endcase
               // Register zero never takes a value
               if (INSTR_IN.dest == 5'h00) s_d.rf_wr.wr_en = 1'b0;
            end
            // Processor state writes from elsewhere
            if (STATE_WR_IN) begin
               s_d.fpu_on     = FPU_ON_FLAG_IN;
               s_d.irq_level  = IRQ_LEVEL_IN;
               s_d.prior_mode = PRIOR_MODE_FLAG_IN;
               s_d.window     = WINDOW_POINTER_IN;
               s_d.trap_allow = TRAP_ALLOW_FLAG_IN;
               s_d.supervisor = SUPERVISOR_IN;
            end
            // Status writes gated by FPU enable
            if (FPU_STATE_WR_IN && s_q.fpu_on) s_d.fpu_state_reg = FPU_STATE_DATA_IN;
            if (FPU_QUEUE_PUSH_IN && s_q.fpq_count != 3'(xor_unit_pkg::FPQ_DEPTH)) begin
               s_d.fpq_count = s_q.fpq_count + 3'h1;
            end
         end
         default: begin
            s_d.phase = ST_RESET;
         end
      endcase
      // Watchdog and software reset behave like power-on for the trap
      if (sync_rst) begin
         s_d.phase      = ST_RESET;
         s_d.reset_trap = 1'b1;
         s_d.supervisor = 1'b1;
         s_d.trap_allow = 1'b0;
         s_d.fetch_addr = xor_unit_pkg::RESET_FETCH_ADDR;
         s_d.icr        = xor_unit_pkg::ICR_RESET;
         s_d.fpq_count  = 3'h0;
         s_d.delay_cnt  = 2'h0;
         s_d.rf_wr.wr_en = 1'b0;
         // Other state fields kept as they were
      end
   end

   // -------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------
   // Every field is cleared to zero, then the reset-defined fields get their constants
   always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         s_q            <= '0;
         s_q.phase      <= ST_RESET;
         s_q.reset_trap <= 1'b1;
         s_q.supervisor <= 1'b1;
         s_q.trap_allow <= 1'b0;
         s_q.fetch_addr <= xor_unit_pkg::RESET_FETCH_ADDR;
         s_q.icr        <= xor_unit_pkg::ICR_RESET;
         s_q.fpq_count  <= 3'h0;
      end else begin
         s_q <= s_d;
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   assign RF_WRITE_OUT           = s_q.rf_wr;
   assign ICC_OUT                = s_q.icc;
   assign MUL_STEP_OUT           = s_q.mul_step;
   assign MUL_STEP_TRAP_VIEW_OUT = (s_q.delay_cnt != 2'h0) ? s_q.mul_step_pend : s_q.mul_step;
   assign SUPERVISOR_OUT         = s_q.supervisor;
   assign TRAP_ALLOW_FLAG_OUT    = s_q.trap_allow;
   assign FPU_ON_FLAG_OUT        = s_q.fpu_on;
   assign IRQ_LEVEL_OUT          = s_q.irq_level;
   assign PRIOR_MODE_FLAG_OUT    = s_q.prior_mode;
   assign WINDOW_POINTER_OUT     = s_q.window;
   assign RESET_TRAP_OUT         = s_q.reset_trap;
   assign FETCH_ADDR_OUT         = s_q.fetch_addr;
   assign INSTR_CACHE_CTRL_OUT   = s_q.icr;
   assign FPU_STATE_REG_OUT      = s_q.fpu_state_reg;
   assign FPU_QUEUE_NONEMPTY_OUT = (s_q.fpq_count != 3'h0);
endmodule
`default_nettype wire

// ### xor_slice_properties.sv
// Assertions on the exclusive-or slice ports
// Assumes: slice package compiled first; bound below by port names
`timescale 1ns/1ps
`default_nettype none
module xor_slice_properties (
   // Clock, resets and stimulus
   input wire logic                    CLOCK_IN,
   input wire logic                    RST_N_IN,
   input wire logic                    WATCHDOG_RST_IN,
   input wire logic                    SOFT_RST_IN,
   input wire xor_unit_pkg::instr_t    INSTR_IN,
   input wire logic [31:0]             SRC1_DATA_IN,
   input wire logic [31:0]             SRC2_DATA_IN,
   input wire logic                    FPU_STATE_WR_IN,
   input wire logic [31:0]             FPU_STATE_DATA_IN,
   // Results and state
   input wire xor_unit_pkg::rf_write_t RF_WRITE_OUT,
   input wire xor_unit_pkg::icc_t      ICC_OUT,
   input wire logic [31:0]             MUL_STEP_TRAP_VIEW_OUT,
   input wire logic                    SUPERVISOR_OUT,
   input wire logic                    TRAP_ALLOW_FLAG_OUT,
   input wire logic                    FPU_ON_FLAG_OUT,
   input wire logic                    RESET_TRAP_OUT,
   input wire logic [31:0]             FPU_STATE_REG_OUT,
   input wire logic                    FPU_QUEUE_NONEMPTY_OUT
);
   logic [31:0] opnd, x;
   logic [3:0]  fx;
   logic        sr, go, lg;
   // Expected operand, result and flags; issue qualifiers
   assign opnd = INSTR_IN.isel ? {{19{INSTR_IN.short_immediate[12]}}, INSTR_IN.short_immediate} : SRC2_DATA_IN;
   assign x    = SRC1_DATA_IN ^ (INSTR_IN.op3[2] ? ~opnd : opnd);
   assign fx   = {x[31], x == 32'h0, 2'h0};
   assign sr   = WATCHDOG_RST_IN | SOFT_RST_IN;
   assign go   = INSTR_IN.valid && INSTR_IN.op == 2'h2 && !RESET_TRAP_OUT && !sr;
   assign lg   = go && INSTR_IN.op3 inside {6'h03, 6'h07, 6'h13, 6'h17};
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!RST_N_IN);
   a_xor_result: assert property (lg && INSTR_IN.dest != 5'h00 |=> RF_WRITE_OUT.wr_en &&
      RF_WRITE_OUT.addr == $past(INSTR_IN.dest) && RF_WRITE_OUT.data == $past(x)) else $error("bad result");
   a_zero_dest: assert property (lg && INSTR_IN.dest == 5'h00 |=> !RF_WRITE_OUT.wr_en)
      else $error("r0 written");
   a_flags_set: assert property (lg && INSTR_IN.op3[4] |=> ICC_OUT == $past(fx))
      else $error("bad flags");
   a_flags_keep: assert property (lg && !INSTR_IN.op3[4] |=> $stable(ICC_OUT))
      else $error("flags moved");
   a_trap_view: assert property (go && INSTR_IN.op3 == 6'h30 |=> !RF_WRITE_OUT.wr_en &&
      MUL_STEP_TRAP_VIEW_OUT == $past(x)) else $error("bad trap view");
   a_sync_reset: assert property (sr |=> RESET_TRAP_OUT && SUPERVISOR_OUT &&
      !TRAP_ALLOW_FLAG_OUT && !FPU_QUEUE_NONEMPTY_OUT) else $error("bad reset state");
   a_trap_once: assert property (RESET_TRAP_OUT && !sr |=> !RESET_TRAP_OUT)
      else $error("reset trap stuck");
   a_fsr_gate: assert property (FPU_STATE_WR_IN && !sr && !RESET_TRAP_OUT |=> FPU_STATE_REG_OUT ==
      ($past(FPU_ON_FLAG_OUT) ? $past(FPU_STATE_DATA_IN) : $past(FPU_STATE_REG_OUT))) else $error("fsr gate");
endmodule
bind xor_logic_y_write_reset xor_slice_properties chk (.*);
`default_nettype wire

// ### xor_feed_model.sv
// Fetch/decode stage and register file feeding the slice
// Assumes: the bench calls issue and idle just after a falling edge
`timescale 1ns/1ps
`default_nettype none
module xor_feed_model (
   // Instruction and operands to the slice
   output var xor_unit_pkg::instr_t instr_out,
   output logic [31:0]              src1_out,
   output logic [31:0]              src2_out
);
   logic [31:0] regs [32];
   // Known register contents; register zero reads as zero
   initial foreach (regs[k]) regs[k] = 32'h1234_5670 + k;
   assign src1_out = (instr_out.src1 == 5'h00) ? 32'h0 : regs[instr_out.src1];
   assign src2_out = (instr_out.src2 == 5'h00) ? 32'h0 : regs[instr_out.src2];
   initial instr_out = '0;
   // Presents one arithmetic-format instruction until the next call
   task automatic issue(input logic [5:0] c, input logic [4:0] d, a, b, input logic i, input logic [12:0] m);
      instr_out = {1'b1, d, a, b, i, m, xor_unit_pkg::OP_ARITH, c};
   endtask
   // Drops valid and scrambles the stale fields
   task automatic idle();
      instr_out = {1'b0, ~instr_out[36:0]};
   endtask
endmodule
`default_nettype wire

// ### xor_logic_y_write_reset_test.sv
// Self-checking bench for the exclusive-or slice
// Assumes: package, slice, feed model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module xor_logic_y_write_reset_test;
   logic clk = 1'b0, rst_n = 1'b0, wd = 1'b0, sw = 1'b0, trap = 1'b0, st_wr = 1'b0, fon = 1'b0;
   logic pm = 1'b1, ta = 1'b0, sup = 1'b0, fw = 1'b0, qp = 1'b0, sup_o, ta_o, fon_o, pm_o, rt, qne;
   logic [3:0] irq = 4'hF, irq_o;
   logic [4:0] wp = 5'h03, wp_o;
   logic [31:0] fd = 32'h0000_0C01, s1, s2, ms, msv, fa, fpu_state_reg, e_y;
   logic [7:0] icr;
   xor_unit_pkg::instr_t instr;
   xor_unit_pkg::rf_write_t rfw;
   xor_unit_pkg::icc_t icc;
   int errors = 0, n_checks = 0;
   // Clock and the two parties
   always #10 clk = ~clk;
   xor_feed_model feed (.instr_out(instr), .src1_out(s1), .src2_out(s2));
   xor_logic_y_write_reset dut (
      .CLOCK_IN(clk), .RST_N_IN(rst_n), .WATCHDOG_RST_IN(wd), .SOFT_RST_IN(sw), .INSTR_IN(instr),
      .SRC1_DATA_IN(s1), .SRC2_DATA_IN(s2), .TRAP_IN(trap), .STATE_WR_IN(st_wr), .FPU_ON_FLAG_IN(fon),
      .IRQ_LEVEL_IN(irq), .PRIOR_MODE_FLAG_IN(pm), .WINDOW_POINTER_IN(wp), .TRAP_ALLOW_FLAG_IN(ta),
      .SUPERVISOR_IN(sup), .FPU_STATE_WR_IN(fw), .FPU_STATE_DATA_IN(fd), .FPU_QUEUE_PUSH_IN(qp),
      .RF_WRITE_OUT(rfw), .ICC_OUT(icc), .MUL_STEP_OUT(ms), .MUL_STEP_TRAP_VIEW_OUT(msv),
      .SUPERVISOR_OUT(sup_o), .TRAP_ALLOW_FLAG_OUT(ta_o), .FPU_ON_FLAG_OUT(fon_o), .IRQ_LEVEL_OUT(irq_o),
      .PRIOR_MODE_FLAG_OUT(pm_o), .WINDOW_POINTER_OUT(wp_o), .RESET_TRAP_OUT(rt), .FETCH_ADDR_OUT(fa),
      .INSTR_CACHE_CTRL_OUT(icr), .FPU_STATE_REG_OUT(fpu_state_reg), .FPU_QUEUE_NONEMPTY_OUT(qne));
   // Counts a comparison and reports a miss
   task automatic chk(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'b1) begin
         errors++;
         $display("FAIL %0t %s", $time, m);
      end
   endtask
   task automatic summarize();
      if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // State load pulse, then one quiet cycle
   task automatic set_state(input logic f, input logic t);
      st_wr = 1'b1;
      fon = f;
      ta = t;
      @(negedge clk);
      st_wr = 1'b0;
      @(negedge clk);
   endtask
   task automatic t_power();
      chk(rt === 1'b1 && sup_o === 1'b1 && ta_o === 1'b0 && qne === 1'b0, "power-on state");
      chk(fa === 32'h0 && icr === xor_unit_pkg::ICR_RESET, "power-on fetch");
      rst_n = 1'b1;
      @(negedge clk);
      chk(rt === 1'b0, "reset trap held");
   endtask
   // All four opcodes, both operand sources, back to back
   task automatic t_logic();
      logic [5:0] c [4];
      logic [31:0] o, r;
      logic [3:0] e_f;
      logic [4:0] d;
      c = '{6'h03, 6'h07, 6'h13, 6'h17};
      e_f = 4'h0;
      feed.regs[4] = feed.regs[1] ^ 32'h8000_0000;
      feed.regs[5] = ~feed.regs[1];
      for (int k = 0; k < 8; k++) begin
         d = (k == 0 || k == 5) ? 5'h00 : 5'(k);
         feed.issue(c[k/2], d, 5'h01, 5'(2 + k/2), k[0], 13'h1ABC);
         @(negedge clk);
         o = k[0] ? 32'hFFFF_FABC : feed.regs[2 + k/2];
         r = feed.regs[1] ^ (c[k/2][2] ? ~o : o);
         if (c[k/2][4]) e_f = {r[31], r == 32'h0, 2'h0};
         chk(rfw.wr_en === (d != 5'h00), "write enable");
         chk(d == 5'h00 || (rfw.addr === d && rfw.data === r), "result");
         chk(icc === e_f, "flags");
      end
      feed.idle();
      @(negedge clk);
   endtask
   // Delayed multiply-step write, commit by count and by trap
   task automatic t_mul();
      e_y = feed.regs[1] ^ feed.regs[2];
      feed.issue(6'h30, 5'h09, 5'h01, 5'h02, 1'b0, 13'h0000);
      @(negedge clk);
      chk(rfw.wr_en === 1'b0 && msv === e_y, "pending write");
      for (int j = 0; j < 3; j++) begin
         feed.issue(6'h03, 5'h07, 5'h03, 5'h03, 1'b0, 13'h0000);
         @(negedge clk);
         chk(ms === (j == 2 ? e_y : 32'h0), "commit timing");
      end
      e_y = feed.regs[1] ^ 32'hFFFF_F001;
      feed.issue(6'h30, 5'h00, 5'h01, 5'h02, 1'b1, 13'h1001);
      @(negedge clk);
      feed.idle();
      trap = 1'b1;
      @(negedge clk);
      trap = 1'b0;
      chk(ms === e_y && msv === e_y, "trap commit");
   endtask
   // Watchdog then software reset with the queue occupied
   task automatic t_resets();
      for (int n = 0; n < 2; n++) begin
         qp = 1'b1;
         set_state(1'b1, 1'b0);
         set_state(1'b1, 1'b1);
         qp = 1'b0;
         chk(qne === 1'b1, "queue empty");
         wd = (n == 0);
         sw = (n == 1);
         @(negedge clk);
         wd = 1'b0;
         sw = 1'b0;
         chk(rt === 1'b1 && sup_o === 1'b1 && ta_o === 1'b0 && qne === 1'b0, "sync reset");
         chk(fa === 32'h0 && fon_o === 1'b1 && irq_o === 4'hF && pm_o === 1'b1 && wp_o === 5'h03, "kept");
         // The reset cycle refuses state loads, so let it pass first
         @(negedge clk);
      end
   endtask
   // Status register write gated by the enable flag
   task automatic t_fpu();
      set_state(1'b0, 1'b0);
      fw = 1'b1;
      @(negedge clk);
      fw = 1'b0;
      chk(fpu_state_reg === 32'h0, "fsr written while off");
      set_state(1'b1, 1'b0);
      fw = 1'b1;
      @(negedge clk);
      fw = 1'b0;
      chk(fpu_state_reg === fd, "fsr not written");
   endtask
   // Main sequence after 16 cycles of reset
   initial begin
      repeat (16) @(negedge clk);
      t_power();
      t_logic();
      t_mul();
      t_resets();
      t_fpu();
      summarize();
   end
   // Hang guard, well beyond the sequence length
   initial begin
      repeat (2000) @(posedge clk);
      errors++;
      summarize();
   end
endmodule
`default_nettype wire
